// ### rtl/adcc_pkg.sv
// shared constants and types of the converter control block
package adcc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CC0 = 8'h1f;
   localparam logic [7:0] IDX_RESH = 8'h1e;
   localparam logic [7:0] IDX_RESL = 8'h9e;
   localparam logic [7:0] IDX_CC1 = 8'h9f;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h21;
   localparam logic [7:0] IDX_IRQ_EN = 8'h22;
   // field positions of control register 0
   localparam int CC0_CLK_LSB = 6;
   localparam int CC0_CH_LSB = 3;
   localparam int CC0_GO_BIT = 2;
   localparam int CC0_PWR_BIT = 0;
   // field positions of control register 1
   localparam int CC1_FMT_BIT = 7;
   localparam int CC1_PCFG_LSB = 0;
   // values after reset
   localparam logic [7:0] CC0_RESET = 8'h00;
   localparam logic [7:0] CC1_RESET = 8'h00;
   // analog pin masks chosen by port_config bits 3:2
   localparam logic [7:0] MASK_ALL = 8'hff;
   localparam logic [7:0] MASK_LOW5 = 8'h1f;
   localparam logic [7:0] MASK_LOW3 = 8'h07;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam int PIN_VREF_HI = 3;
   localparam int PIN_VREF_LO = 2;
   // conversion clock choices
   typedef enum logic [1:0] {
      CLK_DIV2 = 2'b00,
      CLK_DIV8 = 2'b01,
      CLK_DIV32 = 2'b10,
      CLK_RC = 2'b11
   } adcc_clk_sel_t;
   localparam logic [8:0] DIV2_CYC = 9'h002;
   localparam logic [8:0] DIV8_CYC = 9'h008;
   localparam logic [8:0] DIV32_CYC = 9'h020;
   // timing: system clock and internal rc period
   localparam int CLK_HZ = 50_000_000;
   localparam int RC_TAD_NS = 4000;
   localparam int RC_TAD_CYC = RC_TAD_NS / (1_000_000_000 / CLK_HZ);
   localparam int RES_BITS = 10;
   localparam int CONV_TADS = 12;
   // successive approximation sequencer states
   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_SAMPLE = 2'b01,
      SAR_CONV = 2'b10,
      SAR_FIN = 2'b11
   } adcc_sar_state_t;
endpackage

// ### rtl/adcc_tad_gen.sv
// conversion clock enable divider
module adcc_tad_gen #(
   parameter int RC_DIV = adcc_pkg::RC_TAD_CYC
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [1:0] clk_sel_in,
   input wire logic run_in,
   input wire logic restart_in,
   output logic tad_en_out
);
   // counter is 9 bits wide
   generate
      if (RC_DIV < 2 || RC_DIV > 511)
      begin : g_bad_div
         $error("rc divide out of range");
      end
   endgenerate
   logic [8:0] cnt_r; // cycles into the current period
   logic [8:0] div_last; // last count of the period
   // period per clock select code
   assign div_last = (clk_sel_in == adcc_pkg::CLK_DIV2) ? adcc_pkg::DIV2_CYC - 9'h001 :
                     (clk_sel_in == adcc_pkg::CLK_DIV8) ? adcc_pkg::DIV8_CYC - 9'h001 :
                     (clk_sel_in == adcc_pkg::CLK_DIV32) ? adcc_pkg::DIV32_CYC - 9'h001 :
                     9'(RC_DIV - 1);
   assign tad_en_out = run_in & (cnt_r >= div_last);
   // restart aligns the first period to the start
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_r <= 9'h000;
      else if (restart_in || tad_en_out)
         cnt_r <= 9'h000;
      else if (run_in)
         cnt_r <= cnt_r + 9'h001;
   end
endmodule // adcc_tad_gen

// ### rtl/adcc_sar.sv
// successive approximation sequencer, twelve periods per result
module adcc_sar #(
   parameter int RES = adcc_pkg::RES_BITS
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic tad_en_in,
   input wire logic cmp_in,
   output logic busy_out,
   output logic sample_out,
   output logic done_out,
   output logic [RES-1:0] trial_out
);
   generate
      if (RES < 2)
      begin : g_bad_res
         $error("resolution too small");
      end
   endgenerate
   adcc_pkg::adcc_sar_state_t st_r; // sequencer state
   logic [RES-1:0] onehot_r; // bit under trial
   logic [RES-1:0] trial_r; // trial code, also the result
   logic done_r; // completion pulse
   logic [3:0] tads_r; // periods seen, for checking only
   assign busy_out = (st_r != adcc_pkg::SAR_IDLE);
   assign sample_out = (st_r == adcc_pkg::SAR_SAMPLE);
   assign done_out = done_r;
   assign trial_out = trial_r;
   // one period sample, one per bit, one to finish
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st_r <= adcc_pkg::SAR_IDLE;
         onehot_r <= '0;
         trial_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (abort_in)
            st_r <= adcc_pkg::SAR_IDLE;
         else if (start_in)
         begin
            st_r <= adcc_pkg::SAR_SAMPLE;
            trial_r <= '0;
         end
         else if (tad_en_in)
         begin
            case (st_r)
               adcc_pkg::SAR_SAMPLE:
               begin
                  // hold from here on; try the top bit
                  st_r <= adcc_pkg::SAR_CONV;
                  onehot_r <= {1'b1, {(RES-1){1'b0}}};
                  trial_r <= {1'b1, {(RES-1){1'b0}}};
               end
               adcc_pkg::SAR_CONV:
               begin
                  // comparator high keeps the trial bit
                  trial_r <= (cmp_in ? trial_r : (trial_r & ~onehot_r)) | (onehot_r >> 1);
                  onehot_r <= onehot_r >> 1;
                  if (onehot_r[0])
                     st_r <= adcc_pkg::SAR_FIN;
               end
               adcc_pkg::SAR_FIN:
               begin
                  st_r <= adcc_pkg::SAR_IDLE;
                  done_r <= 1'b1;
               end
               default:
                  st_r <= adcc_pkg::SAR_IDLE;
            endcase
         end
      end
   end
   // periods since start, watched by the check below
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         tads_r <= 4'h0;
      else if (start_in)
         tads_r <= 4'h0;
      else if (busy_out && tad_en_in)
         tads_r <= tads_r + 4'h1;
   end
   a_conv_twelve: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      done_out |-> tads_r == 4'd12)
      else $error("conversion not twelve periods");
   sequence s_sample_ends;
      sample_out ##0 tad_en_in ##0 !abort_in ##0 !start_in;
   endsequence
   a_sample_then_msb: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      s_sample_ends |=> !sample_out && busy_out && trial_out[RES-1])
      else $error("sample did not hand over to msb trial");
endmodule // adcc_sar

// ### rtl/adcc_ctrl.sv
// converter control block with avalon register slave
//
// Function
// - five or eight analog inputs per variant
// - selected input charges sample stage, then held
// - successive approximation gives ten-bit result
// - software picks references from supply or pins
// - converts in sleep only on rc clock
// - bits 7-6 pick conversion clock
// - bits 5-3 pick analog channel 0-7; the five-input variant keeps the old channel for codes 5-7
// - writing go with power on starts conversion
// - hardware clears go at completion
// - control 0 bit 1 reads zero
// - control 1 sets pins analog or digital
// - low result byte readable, undefined after reset
// - conversion lasts at least twelve periods
// - port read gives zero on analog pins
module adcc_ctrl #(
   parameter int NUM_CH = 8,
   parameter int RC_DIV = adcc_pkg::RC_TAD_CYC
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic irq_out,
   input wire logic sleep_in,
   input wire logic cmp_in,
   input wire logic [7:0] port_pins_in,
   output logic [7:0] port_read_out,
   output logic [2:0] chan_sel_out,
   output logic sample_out,
   output logic hold_out,
   output logic [9:0] dac_out,
   output logic power_on_out,
   output logic vref_hi_pin_out,
   output logic vref_lo_pin_out,
   output logic [7:0] analog_mask_out
);
   // only the two documented variants are served
   generate
      if (NUM_CH != 5 && NUM_CH != 8)
      begin : g_bad_ch
         $error("channel count must be 5 or 8");
      end
   endgenerate

   localparam logic [3:0] NUM_CH_W = 4'(NUM_CH);

   // control register 0 fields
   logic [1:0] clk_sel_r; // conversion clock select
   logic [2:0] chan_field_r; // channel select as written
   logic [2:0] chan_act_r; // channel actually routed
   logic go_r; // go/done flag
   logic pwr_r; // converter power
   // control register 1 fields
   logic fmt_r; // result format select
   logic [3:0] pcfg_r; // port configuration
   // result, deliberately left without reset
   logic [9:0] res_r;
   // interrupt registers
   logic irq_stat_r; // sticky completion flag
   logic irq_en_r; // completion enable
   // bus slave state
   logic ack_r; // second cycle of an access
   logic [7:0] rdata_r; // registered read data
   logic [7:0] port_rd_r; // registered port read

   // bus decode
   logic req; // any access pending
   logic wr_acc; // write taking effect now
   logic [7:0] idx; // word index
   logic [7:0] wd; // write byte
   logic sel_cc0;
   logic sel_cc1;
   logic sel_resh;
   logic sel_resl;
   logic sel_stat;
   logic sel_clr;
   logic sel_en;
   logic wr_cc0;
   logic wr_cc1;
   logic wr_clr;
   logic wr_en;

   assign req = avs_read_in | avs_write_in;
   // one wait cycle on every access, so read data can come from a flop
   assign avs_waitrequest_out = req & ~ack_r;
   assign wr_acc = avs_write_in & ack_r & avs_byteenable_in[0];
   assign idx = avs_address_in[9:2];
   assign wd = avs_writedata_in[7:0];
   assign sel_cc0 = (idx == adcc_pkg::IDX_CC0);
   assign sel_cc1 = (idx == adcc_pkg::IDX_CC1);
   assign sel_resh = (idx == adcc_pkg::IDX_RESH);
   assign sel_resl = (idx == adcc_pkg::IDX_RESL);
   assign sel_stat = (idx == adcc_pkg::IDX_IRQ_STAT);
   assign sel_clr = (idx == adcc_pkg::IDX_IRQ_CLR);
   assign sel_en = (idx == adcc_pkg::IDX_IRQ_EN);
   assign wr_cc0 = wr_acc & sel_cc0;
   assign wr_cc1 = wr_acc & sel_cc1;
   assign wr_clr = wr_acc & sel_clr;
   assign wr_en = wr_acc & sel_en;

   // conversion control
   logic sar_busy;
   logic sar_done;
   logic sar_sample;
   logic [9:0] sar_trial;
   logic tad_en;
   logic tad_run;
   logic start;
   logic abort;
   logic wd_go;
   logic wd_pwr;
   logic rc_sel;
   logic [2:0] wd_chan;

   assign wd_go = wd[adcc_pkg::CC0_GO_BIT];
   assign wd_pwr = wd[adcc_pkg::CC0_PWR_BIT];
   assign wd_chan = wd[adcc_pkg::CC0_CH_LSB +: 3];
   assign rc_sel = (clk_sel_r == adcc_pkg::CLK_RC);
   // start needs power already on and kept on
   assign start = wr_cc0 & wd_go & wd_pwr & pwr_r & (~go_r | sar_done);
   // clearing go or power mid conversion drops it
   assign abort = wr_cc0 & go_r & ~sar_done & (~wd_go | ~wd_pwr);
   // in sleep only the rc clock keeps running
   assign tad_run = pwr_r & sar_busy & (~sleep_in | rc_sel);

   adcc_tad_gen #(
      .RC_DIV(RC_DIV)
   ) u_tad (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .clk_sel_in(clk_sel_r),
      .run_in(tad_run),
      .restart_in(start),
      .tad_en_out(tad_en)
   );

   adcc_sar #(
      .RES(adcc_pkg::RES_BITS)
   ) u_sar (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .start_in(start),
      .abort_in(abort),
      .tad_en_in(tad_en),
      .cmp_in(cmp_in),
      .busy_out(sar_busy),
      .sample_out(sar_sample),
      .done_out(sar_done),
      .trial_out(sar_trial)
   );

   // control register 0; hardware clear loses to a fresh start
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         clk_sel_r <= adcc_pkg::CC0_RESET[adcc_pkg::CC0_CLK_LSB +: 2];
         chan_field_r <= adcc_pkg::CC0_RESET[adcc_pkg::CC0_CH_LSB +: 3];
         go_r <= adcc_pkg::CC0_RESET[adcc_pkg::CC0_GO_BIT];
         pwr_r <= adcc_pkg::CC0_RESET[adcc_pkg::CC0_PWR_BIT];
      end
      else
      begin
         if (wr_cc0)
         begin
            clk_sel_r <= wd[adcc_pkg::CC0_CLK_LSB +: 2];
            chan_field_r <= wd_chan;
            pwr_r <= wd_pwr;
         end
         if (start)
            go_r <= 1'b1;
         else if (sar_done || abort)
            go_r <= 1'b0;
      end
   end

   // routed channel; codes past the variant keep the old one
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         chan_act_r <= adcc_pkg::CC0_RESET[adcc_pkg::CC0_CH_LSB +: 3];
      else if (wr_cc0 && ({1'b0, wd_chan} < NUM_CH_W))
         chan_act_r <= wd_chan;
   end

   // control register 1
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         fmt_r <= adcc_pkg::CC1_RESET[adcc_pkg::CC1_FMT_BIT];
         pcfg_r <= adcc_pkg::CC1_RESET[adcc_pkg::CC1_PCFG_LSB +: 4];
      end
      else if (wr_cc1)
      begin
         fmt_r <= wd[adcc_pkg::CC1_FMT_BIT];
         pcfg_r <= wd[adcc_pkg::CC1_PCFG_LSB +: 4];
      end
   end

   // result capture; no reset, contents undefined until first result
   always_ff @(posedge clk_in)
   begin
      if (sar_done)
         res_r <= sar_trial;
   end

   // sticky flag: a completion in the clear cycle survives
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         irq_stat_r <= 1'b0;
         irq_en_r <= 1'b0;
      end
      else
      begin
         irq_stat_r <= sar_done | (irq_stat_r & ~(wr_clr & wd[0]));
         if (wr_en)
            irq_en_r <= wd[0];
      end
   end
   assign irq_out = irq_stat_r & irq_en_r;

   // pin configuration: analog mask and reference pins
   logic [7:0] mask_base;
   logic [7:0] mask_var;
   logic [7:0] ref_pins;
   assign mask_base = (pcfg_r[3:2] == 2'b00) ? adcc_pkg::MASK_ALL :
                      (pcfg_r[3:2] == 2'b01) ? adcc_pkg::MASK_LOW5 :
                      (pcfg_r[3:2] == 2'b10) ? adcc_pkg::MASK_LOW3 :
                      adcc_pkg::MASK_NONE;
   assign mask_var = (NUM_CH == 8) ? adcc_pkg::MASK_ALL : adcc_pkg::MASK_LOW5;
   // a pin serving as reference is no longer an input channel
   assign ref_pins = ({7'h00, pcfg_r[0]} << adcc_pkg::PIN_VREF_HI)
                   | ({7'h00, pcfg_r[1]} << adcc_pkg::PIN_VREF_LO);
   assign analog_mask_out = mask_base & mask_var & ~ref_pins;
   assign vref_hi_pin_out = pcfg_r[0];
   assign vref_lo_pin_out = pcfg_r[1];

   // analog pins read as low on the port
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         port_rd_r <= 8'h00;
      else
         port_rd_r <= port_pins_in & ~analog_mask_out;
   end
   assign port_read_out = port_rd_r;

   // analog side controls
   assign chan_sel_out = chan_act_r;
   assign sample_out = sar_sample;
   assign hold_out = sar_busy & ~sar_sample;
   assign dac_out = sar_trial;
   assign power_on_out = pwr_r;

   // read data mux
   logic [7:0] cc0_rd;
   logic [7:0] cc1_rd;
   logic [7:0] resh_rd;
   logic [7:0] resl_rd;
   logic [7:0] rd_mux;
   assign cc0_rd = {clk_sel_r, chan_field_r, go_r, 1'b0, pwr_r};
   assign cc1_rd = {fmt_r, 3'b000, pcfg_r};
   // right justified when format bit set, else left justified
   assign resh_rd = fmt_r ? {6'h00, res_r[9:8]} : res_r[9:2];
   assign resl_rd = fmt_r ? res_r[7:0] : {res_r[1:0], 6'h00};
   assign rd_mux = sel_cc0 ? cc0_rd :
                   sel_cc1 ? cc1_rd :
                   sel_resh ? resh_rd :
                   sel_resl ? resl_rd :
                   sel_stat ? {7'h00, irq_stat_r} :
                   sel_en ? {7'h00, irq_en_r} :
                   8'h00;

   // bus slave: first cycle loads data, second releases waitrequest
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_r <= 1'b0;
         rdata_r <= 8'h00;
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (avs_read_in && !ack_r)
            rdata_r <= rd_mux;
      end
   end
   assign avs_readdata_out = {24'h000000, rdata_r};

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_go_write;
      wr_cc0 && wd_go && wd_pwr && pwr_r && !go_r;
   endsequence
   a_go_starts: assert property (s_go_write |=> go_r && sar_busy)
      else $error("go write did not start conversion");
   a_off_no_start: assert property (!pwr_r && !go_r |=> !go_r)
      else $error("conversion started while powered off");
   a_done_clears: assert property (sar_done && !start |=> !go_r)
      else $error("go not cleared at completion");
   a_done_flags: assert property (sar_done
      |=> irq_stat_r && res_r == $past(sar_trial))
      else $error("completion did not load result and flag");
   sequence s_read_cc0;
      avs_read_in && sel_cc0 && !ack_r ##1 avs_read_in && ack_r;
   endsequence
   a_bit1_zero: assert property (s_read_cc0
      |-> !avs_waitrequest_out && !avs_readdata_out[1])
      else $error("unused bit reads nonzero");
   a_sleep_stall: assert property (sleep_in && !rc_sel |-> !tad_en)
      else $error("conversion clock ran in sleep");
   a_port_masked: assert property (##1
      (port_read_out & $past(analog_mask_out)) == 8'h00)
      else $error("analog pin read nonzero");
   a_chan_limit: assert property ({1'b0, chan_sel_out} < NUM_CH_W)
      else $error("channel beyond variant");
   a_clk_field: assert property (wr_cc0 |=> clk_sel_r == $past(wd[7:6]))
      else $error("clock select not stored");
   a_irq_level: assert property (irq_stat_r && irq_en_r
      && !wr_clr && !wr_en |=> irq_out)
      else $error("enabled flag did not hold interrupt");
endmodule // adcc_ctrl

// ### tb/adcc_analog_model.sv
// analog side of the converter: pin levels, hold capacitor and comparator
module adcc_analog_model #(
   parameter logic [9:0] BASE = 10'h3a7,
   parameter logic [9:0] STEP = 10'h071
) (
   input wire logic clk_in,
   input wire logic [2:0] chan_sel_in,
   input wire logic sample_in,
   input wire logic [9:0] dac_in,
   output logic cmp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_r = 10'h000; // level kept on the hold capacitor
   // capacitor tracks the routed pin while sampling and keeps it afterwards
   always @(posedge clk_in)
   begin
      // each pin sits at its own fixed level, so a wrong route shows up
      if (sample_in)
      begin
         held_r <= BASE - 10'(chan_sel_in) * STEP;
      end
   end
   // comparator: one when held level is at or above the trial code
   assign cmp_out = (held_r >= dac_in);
endmodule // adcc_analog_model

// ### tb/tb.sv
// self-checking testbench of the converter control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC = 80; // rc period of 1.6 us, the shortest accurate one
   localparam logic [9:0] BASE = 10'h3a7; // level of pin 0
   localparam logic [9:0] STEP = 10'h071; // level drop per pin
   logic clk_in = 1'b0; // system clock
   logic arst_n_in = 1'b0; // reset, active low
   logic [9:0] avs_address_in = 10'h000; // bus address
   logic avs_read_in = 1'b0; // bus read
   logic avs_write_in = 1'b0; // bus write
   logic [31:0] avs_writedata_in = 32'h00000000; // bus write data
   logic [3:0] avs_byteenable_in = 4'h0; // bus byte enables
   logic [31:0] avs_readdata_out; // bus read data
   logic avs_waitrequest_out; // bus stall
   logic irq_out; // interrupt level
   logic sleep_in = 1'b0; // device sleeping
   logic cmp_in; // comparator from analog model
   logic [7:0] port_pins_in = 8'h00; // digital pin levels
   logic [7:0] port_read_out; // port read value
   logic [2:0] chan_sel_out; // routed channel
   logic sample_out; // sampling phase
   logic hold_out; // trial phase
   logic [9:0] dac_out; // trial code
   logic power_on_out; // converter power
   logic vref_hi_pin_out; // high reference from pin
   logic vref_lo_pin_out; // low reference from pin
   logic [7:0] analog_mask_out; // analog pin mask
   logic [3:0] be = 4'h1; // byte enables for the next access
   int errors = 0; // mismatches
   int checks = 0; // comparisons
   int cyc = 0; // free cycle count
   logic [2:0] ch5; // channel routed by the five-input variant
   logic [7:0] mask5; // analog mask of the five-input variant
   adcc_ctrl #(.NUM_CH(8), .RC_DIV(RC)) i_dut (.*);
   // five-input variant shares the bus; only its routing and mask are watched
   adcc_ctrl #(.NUM_CH(5), .RC_DIV(RC)) i_dut5 (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(), .avs_waitrequest_out(),
      .irq_out(), .sleep_in(sleep_in), .cmp_in(cmp_in), .port_pins_in(port_pins_in),
      .port_read_out(), .chan_sel_out(ch5), .sample_out(), .hold_out(), .dac_out(),
      .power_on_out(), .vref_hi_pin_out(), .vref_lo_pin_out(), .analog_mask_out(mask5));
   adcc_analog_model #(.BASE(BASE), .STEP(STEP)) i_model (.clk_in(clk_in),
      .chan_sel_in(chan_sel_out), .sample_in(sample_out), .dac_in(dac_out), .cmp_out(cmp_in));
   // 50 MHz clock
   initial
   begin
      forever #10 clk_in = ~clk_in;
   end
   // cycle count for conversion length
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
   end
   // verdict and end of run
   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus access; request held until waitrequest is low at a rising edge
   task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] q);
      logic ok;
      int n;
      ok = 1'b0;
      n = 0;
      q = 8'h00;
      avs_read_in <= rd;
      avs_write_in <= ~rd;
      avs_address_in <= {idx, 2'b00};
      avs_writedata_in <= {24'h000000, wd};
      avs_byteenable_in <= be;
      // sampled at the rising edge itself, before that edge's updates land
      do
      begin
         @(posedge clk_in);
         n++;
         ok = (avs_waitrequest_out === 1'b0);
         q = avs_readdata_out[7:0];
      end
      while (!ok && n < 50);
      if (!ok)
      begin
         errors++;
         final_report();
      end
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask
   // register write
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b0, idx, d, q);
   endtask
   // register read and compare
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b1, idx, 8'h00, q);
      chk(10'(q), 10'(exp));
   endtask
   // full conversion: clock choice, channel, result format, sleep
   task automatic conv(input logic [1:0] sel, input logic [2:0] ch, input logic fmt,
                       input logic slp);
      logic [7:0] q;
      logic [9:0] r;
      int t0;
      int div;
      r = BASE - 10'(ch) * STEP;
      div = (sel == 2'b00) ? 2 : (sel == 2'b01) ? 8 : (sel == 2'b10) ? 32 : RC;
      wr(adcc_pkg::IDX_CC1, {fmt, 7'h00});
      wr(adcc_pkg::IDX_CC0, {sel, ch, 3'b001});
      sleep_in <= slp;
      wr(adcc_pkg::IDX_CC0, {sel, ch, 3'b101});
      t0 = cyc;
      chk(10'(chan_sel_out), 10'(ch));
      // oscillator clocks stand still in sleep, so the conversion must wait
      if (slp && sel != 2'b11)
      begin
         repeat (60) @(posedge clk_in);
         rdchk(adcc_pkg::IDX_CC0, {sel, ch, 3'b101});
         sleep_in <= 1'b0;
      end
      // poll go until hardware clears it
      do
         bus(1'b1, adcc_pkg::IDX_CC0, 8'h00, q);
      while (q[2] === 1'b1 && cyc - t0 < 3000);
      chk(10'(q), 10'({sel, ch, 3'b001}));
      chk(10'(cyc - t0 >= 12 * div), 10'h001);
      rdchk(adcc_pkg::IDX_RESH, fmt ? {6'h00, r[9:8]} : r[9:2]);
      rdchk(adcc_pkg::IDX_RESL, fmt ? r[7:0] : {r[1:0], 6'h00});
      rdchk(adcc_pkg::IDX_IRQ_STAT, 8'h01);
      sleep_in <= 1'b0;
   endtask
   // hang guard: 20,000 cycles, far above the expected few thousand
   initial
   begin
      #400_000;
      errors++;
      final_report();
   end
   // main sequence
   initial
   begin
      static logic [3:0] pc [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h3};
      static logic [7:0] mk [5] = '{8'hff, 8'h1f, 8'h07, 8'h00, 8'hf3};
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      rdchk(adcc_pkg::IDX_CC0, 8'h00);
      rdchk(adcc_pkg::IDX_CC1, 8'h00);
      // go written together with power while off is ignored
      wr(adcc_pkg::IDX_CC0, 8'h05);
      rdchk(adcc_pkg::IDX_CC0, 8'h01);
      chk(10'(power_on_out), 10'h001);
      wr(adcc_pkg::IDX_CC0, 8'h3e);
      rdchk(adcc_pkg::IDX_CC0, 8'h38);
      chk(10'(power_on_out), 10'h000);
      chk(10'(ch5), 10'h000);
      chk(10'(mask5), 10'h01f);
      // unmapped place and disabled byte lane
      wr(8'hff, 8'h5a);
      rdchk(8'hff, 8'h00);
      be = 4'h0;
      wr(adcc_pkg::IDX_CC1, 8'h8c);
      be = 4'h1;
      rdchk(adcc_pkg::IDX_CC1, 8'h00);
      // pin configuration table
      port_pins_in <= 8'hb5;
      for (int i = 0; i < 5; i++)
      begin
         wr(adcc_pkg::IDX_CC1, {4'h0, pc[i]});
         // port read is registered, so let it take the new mask first
         @(posedge clk_in);
         chk(10'(analog_mask_out), 10'(mk[i]));
         chk(10'(port_read_out), 10'(8'hb5 & ~mk[i]));
         chk(10'({vref_lo_pin_out, vref_hi_pin_out}), 10'(pc[i][1:0]));
      end
      // every clock choice, both formats, interrupt raised and cleared
      // oscillator divides run faster than a real converter allows; the ideal model copes
      wr(adcc_pkg::IDX_IRQ_EN, 8'h01);
      for (int s = 0; s < 6; s++)
      begin
         conv(2'(s % 4), 3'(2 * s + 1), s[0], s > 3);
         chk(10'(irq_out), 10'h001);
         wr(adcc_pkg::IDX_IRQ_CLR, 8'h01);
         rdchk(adcc_pkg::IDX_IRQ_STAT, 8'h00);
         chk(10'(irq_out), 10'h000);
      end
      // masked: flag set but no interrupt; rc clock keeps converting in sleep
      wr(adcc_pkg::IDX_IRQ_EN, 8'h00);
      conv(2'b11, 3'd4, 1'b1, 1'b1);
      chk(10'(irq_out), 10'h000);
      chk(10'(ch5), 10'h004);
      rdchk(adcc_pkg::IDX_IRQ_CLR, 8'h00);
      final_report();
   end
endmodule // tb
